// ---- include/gauge_stats_cfg.svh ----
// Purpose: Offsets, reset values, field positions and timing periods of the gauge statistics.
// Assumes: Included by its bare name; definitions only.
// Notes: Times are kept in their own unit; cycle counts derive from the clock rate.
`ifndef GAUGE_STATS_CFG_SVH
`define GAUGE_STATS_CFG_SVH

`define OFS_AVG_VCELL 8'h19
`define OFS_TEMP_EXT 8'h1A
`define OFS_VOLT_EXT 8'h1B
`define OFS_CURR_EXT 8'h1C
`define OFS_THERM_RATIO 8'h27

`define RST_AVG_VCELL 16'hB400
`define RST_TEMP_EXT 16'h807F
`define RST_VOLT_EXT 16'h00FF
`define RST_CURR_EXT 16'h807F
`define RST_THERM_RATIO 16'h88D0

// Lowest bit of each reading that lands in its 8-bit extreme field.
`define TEMP_FIELD_LSB 8
`define VOLT_FIELD_LSB 8
`define CURR_FIELD_LSB 8

// Averaging shift: span selector 0 gives the shortest span, 7 the longest.
`define AVG_SHIFT_MIN 4'h6

// Voltage trim gain has unity at bit 15; thermistor gain has unity at bit 14.
`define VOLT_GAIN_FRAC 15
`define THERM_GAIN_FRAC 14

`define CLK_MHZ 200
`define VOLT_PERIOD_US 175800
`define TEMP_PERIOD_US 1400000

`endif

// ---- include/gauge_stats_pkg.sv ----
// Purpose: Types shared by the gauge statistics block and its users.
// Assumes: Constants live in gauge_stats_cfg.svh.
// Notes: None.
package gauge_stats_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] data;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } reg_rsp_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } ext_pair_t;

endpackage : gauge_stats_pkg

// ---- rtl/gauge_measurement_statistics.sv ----
// Purpose: Averaged cell voltage, min/max trackers and thermistor ratio of a fuel gauge.
// Assumes: Front-end results arrive on clk_sys; registers are reached by the register port.
// Notes: A host write in the same cycle as a hardware update wins.
`timescale 1ns/1ps
`include "gauge_stats_cfg.svh"

// Operation
// - IIR average of cell voltage, selectable span
// - First voltage result seeds the average directly
// - Temperature max high byte, min low byte
// - Temperature extremes reset to 0x80 and 0x7F
// - Each temperature update widens max or min
// - Temperature extremes signed, 1 degree steps
// - Voltage extremes reset to 00h and FFh
// - Each voltage update widens max or min
// - Voltage max high, min low, 20mV steps
// - Current extremes reset to 80h and 7Fh
// - Each current update widens max or min
// - Current extremes signed, 8.567mA steps
// - Thermistor ratio reported as 16-bit value
// - Ratio converted by gain, offset, curve
// - Voltage sampled every 175.8ms and trimmed
// - New temperature measurement every 1.4 seconds
// - Current saturates at largest or smallest code
module gauge_measurement_statistics #(
  parameter int unsigned VOLT_CYCLES = `VOLT_PERIOD_US * `CLK_MHZ,
  parameter int unsigned TEMP_CYCLES = `TEMP_PERIOD_US * `CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire gauge_stats_pkg::reg_req_t regReq,
  output gauge_stats_pkg::reg_rsp_t regRsp,
  input wire logic [15:0] rawVoltageSample,
  input wire logic [15:0] voltGain,
  input wire logic [15:0] voltOffset,
  input wire logic [2:0] avgSpan,
  input wire logic [15:0] tempSample,
  input wire logic currValid,
  input wire logic signed [17:0] currRaw,
  input wire logic thermValid,
  input wire logic [15:0] thermRatioIn,
  input wire logic [15:0] thermistorGain,
  input wire logic [15:0] thermistorOffset,
  input wire logic [15:0] thermistorCurve,
  output logic [15:0] cellVoltage,
  output logic [15:0] tempReading,
  output logic [15:0] currentReading,
  output logic [15:0] thermTemp
);
  import gauge_stats_pkg::*;

  // Widens a max/min pair with one new sample; the compare is signed or unsigned.
  function automatic ext_pair_t trackExt(ext_pair_t cur, logic [7:0] s, logic isSigned);
    ext_pair_t res;
    logic gt;
    logic lt;
    res = cur;
    gt = isSigned ? ($signed(s) > $signed(cur.high)) : (s > cur.high);
    lt = isSigned ? ($signed(s) < $signed(cur.low)) : (s < cur.low);
    if (gt)
    begin
      res.high = s;
    end
    if (lt)
    begin
      res.low = s;
    end
    return res;
  endfunction : trackExt

  logic [31:0] voltCnt_r;
  logic [31:0] tempCnt_r;
  logic [31:0] avgAcc_r;
  logic avgSeeded_r;
  ext_pair_t tempExt_r;
  ext_pair_t voltExt_r;
  ext_pair_t currExt_r;
  logic [15:0] thermRatio_r;

  wire voltTick = (voltCnt_r == VOLT_CYCLES - 32'h1);
  wire tempTick = (tempCnt_r == TEMP_CYCLES - 32'h1);

  wire wrAvg = regReq.wr && (regReq.addr == `OFS_AVG_VCELL);
  wire wrTemp = regReq.wr && (regReq.addr == `OFS_TEMP_EXT);
  wire wrVolt = regReq.wr && (regReq.addr == `OFS_VOLT_EXT);
  wire wrCurr = regReq.wr && (regReq.addr == `OFS_CURR_EXT);
  wire wrTherm = regReq.wr && (regReq.addr == `OFS_THERM_RATIO);

  // Trimmed voltage: gain with unity at bit 15, then a signed offset.
  wire [31:0] voltProd = rawVoltageSample * voltGain;
  wire [15:0] voltScaled = voltProd[`VOLT_GAIN_FRAC +: 16];
  wire [15:0] vcellNxt = voltScaled + voltOffset;

  // IIR step: the accumulator moves by its error shifted down by 6 plus the span.
  wire [3:0] avgShift = `AVG_SHIFT_MIN + {1'b0, avgSpan};
  wire signed [32:0] avgErr = $signed({1'b0, vcellNxt, 16'h0000}) - $signed({1'b0, avgAcc_r});
  wire signed [32:0] avgStep = avgErr >>> avgShift;
  wire [32:0] avgSum = {1'b0, avgAcc_r} + avgStep;
  wire [31:0] avgAccNxt = avgSum[31:0];
  wire [15:0] avgVoltage = avgAcc_r[31:16];

  // Readings are cut down to the field resolution before any compare.
  wire [7:0] tempByte = tempSample[`TEMP_FIELD_LSB +: 8];
  wire [7:0] voltByte = vcellNxt[`VOLT_FIELD_LSB +: 8];
  wire [15:0] currSat = (currRaw > 18'sh07FFF) ? 16'h7FFF :
                        (currRaw < -18'sh08000) ? 16'h8000 : currRaw[15:0];
  wire [7:0] currByte = currSat[`CURR_FIELD_LSB +: 8];

  wire ext_pair_t tempExtNxt = trackExt(tempExt_r, tempByte, 1'b1);
  wire ext_pair_t voltExtNxt = trackExt(voltExt_r, voltByte, 1'b0);
  wire ext_pair_t currExtNxt = trackExt(currExt_r, currByte, 1'b1);

  // Thermistor conversion: linear gain and offset plus a square-law bend about mid-scale.
  wire signed [32:0] thGainProd = $signed({1'b0, thermRatio_r}) * $signed(thermistorGain);
  wire signed [8:0] thDev = $signed({1'b0, thermRatio_r[15:8]}) - 9'sh080;
  wire signed [17:0] thSq = thDev * thDev;
  wire signed [34:0] thCurveProd = $signed(thermistorCurve) * thSq;
  wire [15:0] thLinear = thGainProd[`THERM_GAIN_FRAC +: 16];
  wire [15:0] thermTempNxt = thLinear + thermistorOffset + thCurveProd[31:16];

  wire [15:0] rdMux =
    (regReq.addr == `OFS_AVG_VCELL) ? avgVoltage :
    (regReq.addr == `OFS_TEMP_EXT) ? tempExt_r :
    (regReq.addr == `OFS_VOLT_EXT) ? voltExt_r :
    (regReq.addr == `OFS_CURR_EXT) ? currExt_r :
    (regReq.addr == `OFS_THERM_RATIO) ? thermRatio_r : 16'h0000;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      voltCnt_r <= 32'h0;
      tempCnt_r <= 32'h0;
    end
    else if (ce)
    begin
      voltCnt_r <= voltTick ? 32'h0 : voltCnt_r + 32'h1;
      tempCnt_r <= tempTick ? 32'h0 : tempCnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      avgAcc_r <= {`RST_AVG_VCELL, 16'h0000};
      avgSeeded_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wrAvg)
      begin
        avgAcc_r <= {regReq.data, 16'h0000};
        avgSeeded_r <= 1'b1;
      end
      else if (voltTick)
      begin
        avgAcc_r <= avgSeeded_r ? avgAccNxt : {vcellNxt, 16'h0000};
        avgSeeded_r <= 1'b1;
      end
    end
  end

  // Writing the power-up pattern is the host's clear; any other value is stored as written.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tempExt_r <= `RST_TEMP_EXT;
      voltExt_r <= `RST_VOLT_EXT;
      currExt_r <= `RST_CURR_EXT;
    end
    else if (ce)
    begin
      if (wrTemp)
        tempExt_r <= regReq.data;
      else if (tempTick)
        tempExt_r <= tempExtNxt;
      if (wrVolt)
        voltExt_r <= regReq.data;
      else if (voltTick)
        voltExt_r <= voltExtNxt;
      if (wrCurr)
        currExt_r <= regReq.data;
      else if (currValid)
        currExt_r <= currExtNxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      thermRatio_r <= `RST_THERM_RATIO;
      thermTemp <= 16'h0000;
    end
    else if (ce)
    begin
      if (wrTherm)
        thermRatio_r <= regReq.data;
      else if (thermValid)
        thermRatio_r <= thermRatioIn;
      thermTemp <= thermTempNxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cellVoltage <= 16'h0000;
      tempReading <= 16'h0000;
      currentReading <= 16'h0000;
    end
    else if (ce)
    begin
      if (voltTick)
        cellVoltage <= vcellNxt;
      if (tempTick)
        tempReading <= tempSample;
      if (currValid)
        currentReading <= currSat;
    end
  end

  // The read answer is registered, so data appears one cycle after the strobe.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      regRsp <= '0;
    else if (ce)
    begin
      regRsp.valid <= regReq.rd;
      if (regReq.rd)
        regRsp.data <= rdMux;
    end
  end

  sequence s_voltSample;
    ce && voltTick && !wrAvg;
  endsequence

  sequence s_tempSample;
    ce && tempTick && !wrTemp;
  endsequence

  property p_avgSeed;
    @(posedge clk_sys) disable iff (rst)
      s_voltSample and (!avgSeeded_r) |=> (avgVoltage == $past(vcellNxt));
  endproperty
  a_avgSeed: assert property (p_avgSeed) else $error("average not seeded");

  property p_avgTowards;
    @(posedge clk_sys) disable iff (rst)
      s_voltSample and (avgSeeded_r && (vcellNxt >= avgVoltage))
      |=> (avgVoltage >= $past(avgVoltage)) && (avgVoltage <= $past(vcellNxt));
  endproperty
  a_avgTowards: assert property (p_avgTowards) else $error("average moved away");

  property p_tempMaxRise;
    @(posedge clk_sys) disable iff (rst)
      s_tempSample and ($signed(tempByte) > $signed(tempExt_r.high))
      |=> (tempExt_r.high == $past(tempByte));
  endproperty
  a_tempMaxRise: assert property (p_tempMaxRise) else $error("temp max not raised");

  property p_tempMinHold;
    @(posedge clk_sys) disable iff (rst)
      s_tempSample and ($signed(tempByte) >= $signed(tempExt_r.low))
      |=> $stable(tempExt_r.low);
  endproperty
  a_tempMinHold: assert property (p_tempMinHold) else $error("temp min moved");

  property p_tempClear;
    @(posedge clk_sys) disable iff (rst)
      ce && wrTemp && (regReq.data == `RST_TEMP_EXT) ##1 !(ce && (tempTick || wrTemp))
      |-> (tempExt_r == `RST_TEMP_EXT) ##1 (tempExt_r == `RST_TEMP_EXT);
  endproperty
  a_tempClear: assert property (p_tempClear) else $error("temp clear lost");

  property p_voltMaxRise;
    @(posedge clk_sys) disable iff (rst)
      ce && voltTick && !wrVolt && (voltByte > voltExt_r.high)
      |=> (voltExt_r.high == $past(voltByte));
  endproperty
  a_voltMaxRise: assert property (p_voltMaxRise) else $error("volt max not raised");

  property p_currMinFall;
    @(posedge clk_sys) disable iff (rst)
      ce && currValid && !wrCurr && ($signed(currByte) < $signed(currExt_r.low))
      |=> (currExt_r.low == $past(currByte));
  endproperty
  a_currMinFall: assert property (p_currMinFall) else $error("curr min not lowered");

  property p_currSat;
    @(posedge clk_sys) disable iff (rst)
      ce && currValid && (currRaw > 18'sh07FFF) |=> (currentReading == 16'h7FFF);
  endproperty
  a_currSat: assert property (p_currSat) else $error("current not saturated");

  property p_readAvg;
    @(posedge clk_sys) disable iff (rst)
      ce && regReq.rd && (regReq.addr == `OFS_AVG_VCELL)
      |=> regRsp.valid && (regRsp.data == $past(avgVoltage));
  endproperty
  a_readAvg: assert property (p_readAvg) else $error("average readback wrong");

endmodule : gauge_measurement_statistics

// ---- verif/gauge_measurement_statistics_tb.sv ----
// Purpose: Self-checking bench for the gauge statistics registers and trackers.
// Assumes: Short tick periods; unity trim gains; no curve correction until the thermistor test.
// Notes: Tick-driven scenarios first wait for a tick with wout so the next one cannot land mid-check.
`timescale 1ns/1ps
module gauge_measurement_statistics_tb;
  import gauge_stats_pkg::*;
  localparam int unsigned VC = 40;
  localparam int unsigned TC = 60;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] avgSpan = 3'h0;
  logic [15:0] thermistorCurve = 16'h0000;
  reg_req_t regReq;
  reg_rsp_t regRsp;
  logic [15:0] rawVoltageSample = 16'h1200;
  logic [15:0] voltOffset = 16'h0034;
  logic [15:0] tempSample = 16'hE700;
  logic currValid = 1'b0;
  logic signed [17:0] currRaw = 18'sh00000;
  logic thermValid = 1'b0;
  logic [15:0] thermRatioIn = 16'h0000;
  logic [15:0] thermistorOffset = 16'h0010;
  logic [15:0] cellVoltage, tempReading, currentReading, thermTemp;
  int mismatches = 0;
  int nCompared = 0;
  int cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  host_model host (.clk_sys(clk_sys), .regReq(regReq), .regRsp(regRsp));

  gauge_measurement_statistics #(.VOLT_CYCLES(VC), .TEMP_CYCLES(TC)) uut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .regReq(regReq), .regRsp(regRsp),
    .rawVoltageSample(rawVoltageSample), .voltGain(16'h8000), .voltOffset(voltOffset),
    .avgSpan(avgSpan), .tempSample(tempSample), .currValid(currValid), .currRaw(currRaw),
    .thermValid(thermValid), .thermRatioIn(thermRatioIn), .thermistorGain(16'h4000),
    .thermistorOffset(thermistorOffset), .thermistorCurve(thermistorCurve),
    .cellVoltage(cellVoltage), .tempReading(tempReading),
    .currentReading(currentReading), .thermTemp(thermTemp)
  );

  task automatic end_sim;
    if (mismatches == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    host.access(1'b0, a, 16'h0000, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] d;
    logic ok;
    host.access(1'b1, a, v, d, ok);
  endtask : wr

  task automatic wout(input bit temp, input logic [15:0] e);
    int n = 0;
    while ((temp ? tempReading : cellVoltage) !== e && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(temp ? tempReading : cellVoltage, e);
  endtask : wout

  task automatic curr(input logic signed [17:0] v);
    @(negedge clk_sys);
    currValid = 1'b1;
    currRaw = v;
    @(negedge clk_sys);
    currValid = 1'b0;
  endtask : curr

  task automatic test_reset;
    rd(8'h19, 16'hB400);
    rd(8'h1A, 16'h807F);
    rd(8'h1B, 16'h00FF);
    rd(8'h1C, 16'h807F);
    rd(8'h27, 16'h88D0);
    rd(8'h20, 16'h0000);
    chk(thermTemp, 16'h88E0);
  endtask : test_reset

  // The second sample has its top bit set, so a signed compare would misplace it.
  task automatic test_voltage;
    wout(1'b0, 16'h1234);
    rd(8'h19, 16'h1234);
    rd(8'h1B, 16'h1212);
    rawVoltageSample = 16'h8FCC;
    wout(1'b0, 16'h9000);
    rd(8'h19, 16'h142B);
    rd(8'h1B, 16'h9012);
    wr(8'h1B, 16'h00FF);
    rd(8'h1B, 16'h00FF);
  endtask : test_voltage

  task automatic test_temp;
    tempSample = 16'h1900;
    wout(1'b1, 16'h1900);
    rd(8'h1A, 16'h19E7);
    wr(8'h1A, 16'h807F);
    rd(8'h1A, 16'h807F);
    repeat (TC) @(negedge clk_sys);
    rd(8'h1A, 16'h1919);
  endtask : test_temp

  task automatic test_current;
    curr(-18'sd12288);
    chk(currentReading, 16'hD000);
    rd(8'h1C, 16'hD0D0);
    curr(18'sd80000);
    chk(currentReading, 16'h7FFF);
    curr(-18'sd100000);
    chk(currentReading, 16'h8000);
    rd(8'h1C, 16'h7F80);
    wr(8'h1C, 16'h807F);
    rd(8'h1C, 16'h807F);
    curr(18'sd256);
    rd(8'h1C, 16'h0101);
  endtask : test_current

  task automatic test_therm;
    @(negedge clk_sys);
    thermValid = 1'b1;
    thermRatioIn = 16'h4000;
    @(negedge clk_sys);
    thermValid = 1'b0;
    rd(8'h27, 16'h4000);
    chk(thermTemp, 16'h4010);
    thermistorOffset = 16'h0000;
    wr(8'h27, 16'h1234);
    rd(8'h27, 16'h1234);
    chk(thermTemp, 16'h1234);
    thermistorCurve = 16'h0100;
    repeat (2) @(negedge clk_sys);
    chk(thermTemp, 16'h1263);
  endtask : test_therm

  // With the longest span one step moves the average 128 times less than with the shortest.
  task automatic test_span;
    rawVoltageSample = 16'h8FCD;
    wout(1'b0, 16'h9001);
    avgSpan = 3'h7;
    wr(8'h19, 16'h1000);
    rawVoltageSample = 16'h8FCC;
    wout(1'b0, 16'h9000);
    rd(8'h19, 16'h1004);
  endtask : test_span

  // One edge passes first so the last read's answer is gone before the freeze.
  task automatic test_ce;
    logic [15:0] d;
    logic ok;
    @(negedge clk_sys);
    ce = 1'b0;
    rawVoltageSample = 16'h8FCE;
    host.access(1'b0, 8'h19, 16'h0000, d, ok);
    chk({15'h0000, ok}, 16'h0000);
    repeat (VC) @(negedge clk_sys);
    chk(cellVoltage, 16'h9000);
    ce = 1'b1;
    wout(1'b0, 16'h9002);
  endtask : test_ce

  task automatic test_rerst;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(cellVoltage, 16'h0000);
    rd(8'h1A, 16'h807F);
    rd(8'h1B, 16'h00FF);
    rd(8'h1C, 16'h807F);
    rd(8'h19, 16'hB400);
  endtask : test_rerst

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      end_sim();
    end
  end

  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    test_reset();
    test_voltage();
    test_temp();
    test_current();
    test_therm();
    test_span();
    test_ce();
    test_rerst();
    end_sim();
  end
endmodule : gauge_measurement_statistics_tb

// ---- verif/host_model.sv ----
// Purpose: Host side of the register port, issuing one read or write at a time.
// Assumes: Requests launch on the falling edge and are taken on the next rising edge.
// Notes: Idle address and data show the inverse of the last request, never a stale copy.
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  output gauge_stats_pkg::reg_req_t regReq,
  input wire gauge_stats_pkg::reg_rsp_t regRsp
);
  import gauge_stats_pkg::*;

  initial regReq = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, data: 16'hFFFF};

  // Response is sampled at the falling edge after the taking edge, where it stands settled.
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] wd,
                        output logic [15:0] rdata, output logic ok);
    @(negedge clk_sys);
    regReq = '{wr: w, rd: !w, addr: a, data: wd};
    @(negedge clk_sys);
    ok = w | regRsp.valid;
    rdata = regRsp.data;
    regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~wd};
  endtask : access
endmodule : host_model
